// file: shared/aocfg_defs.svh
`ifndef AOCFG_DEFS_SVH
`define AOCFG_DEFS_SVH
// Register offsets
`define AOCFG_OFS_OVERLOAD 8'h02
`define AOCFG_OFS_LOOPBW 8'h03
`define AOCFG_OFS_CLIPGAIN 8'h0a
`define AOCFG_OFS_EQUALIZER 8'h0b
`define AOCFG_OFS_OUTDRV 8'h0c
`define AOCFG_OFS_GAIN 8'h10
`define AOCFG_OFS_CLAMP 8'h11
// Field positions
`define AOCFG_BIT_RECOVERY 4
`define AOCFG_BIT_LOOPBW 1
`define AOCFG_BIT_CUSTOM_GAIN 7
`define AOCFG_BIT_EQ_DISABLE 0
`define AOCFG_BIT_LOW_SWING 0
`define AOCFG_BIT_CM_SELECT 1
`define AOCFG_DRIVE_LSB 2
`define AOCFG_BIT_TERM 4
// Reset and default values
`define AOCFG_RST_CTRL 8'h00
`define AOCFG_DEF_GAIN 8'h80
`define AOCFG_DEF_CLAMP 8'hc0
`define AOCFG_CUSTOM_GAIN 8'h60
`define AOCFG_CUSTOM_CLAMP 8'ha0
// Timing: input sample period and oversampling
`define AOCFG_OSR 16
`define AOCFG_WORD_BITS 12
`define AOCFG_BIT_RATIO 6
`endif

// file: shared/aocfg_pkg.sv
package aocfg_pkg;
  typedef enum logic [1:0] {
    AOCFG_MODE_REDUCED_CM = 2'b00,
    AOCFG_MODE_STANDARD = 2'b01,
    AOCFG_MODE_LOW_SWING = 2'b10
  } aocfg_outmode_t;
  typedef enum logic [1:0] {
    AOCFG_DRIVE_2P5 = 2'b00,
    AOCFG_DRIVE_3P5 = 2'b01,
    AOCFG_DRIVE_5P0 = 2'b10
  } aocfg_drive_t;
  typedef enum logic [1:0] {
    AOCFG_SPI_IDLE = 2'b00,
    AOCFG_SPI_ADDR = 2'b01,
    AOCFG_SPI_DATA = 2'b10
  } aocfg_spi_t;
endpackage

// file: src/aocfg_clamp.sv
`timescale 1ns/1ps
`include "aocfg_defs.svh"
// One channel of overload limiting: soft clamp then digital hard limit
module aocfg_clamp
  import aocfg_pkg::*;
#(
  parameter int W = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic os_tick,
  input wire logic recovery_on,
  input wire logic [7:0] clamp_lim,
  input wire logic [7:0] gain_lim,
  // Sample path
  input wire logic signed [W-1:0] sample_in,
  output logic signed [W-1:0] sample_out,
  output logic over_range
);
  logic signed [W-1:0] out_q, out_d;
  logic over_q, over_d;
  logic signed [W:0] clamp_v, gain_v;

  // Limits scale the 8-bit fields onto the sample magnitude
  always_comb begin
    clamp_v = $signed({1'b0, clamp_lim, {(W-8){1'b0}}});
    gain_v = $signed({1'b0, gain_lim, {(W-8){1'b0}}});
    out_d = out_q;
    over_d = over_q;
    if (os_tick) begin
      out_d = sample_in;
      over_d = 1'b0;
      if (recovery_on) begin
        if ($signed({sample_in[W-1], sample_in}) > clamp_v) begin
          out_d = clamp_v[W-1:0];
        end else if ($signed({sample_in[W-1], sample_in}) < -clamp_v) begin
          out_d = W'(-clamp_v);
        end
        if ($signed({out_d[W-1], out_d}) > gain_v) begin
          out_d = {1'b0, {(W-1){1'b1}}};
          over_d = 1'b1;
        end else if ($signed({out_d[W-1], out_d}) < -gain_v) begin
          out_d = {1'b1, {(W-1){1'b0}}};
          over_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= '0;
      over_q <= 1'b0;
    end else begin
      out_q <= out_d;
      over_q <= over_d;
    end
  end

  assign sample_out = out_q;
  assign over_range = over_q;
endmodule

// file: src/aocfg_top.sv
`timescale 1ns/1ps
`include "aocfg_defs.svh"
// Functional notes
// - Reset leaves recovery off, wide full-scale, conventional settling.
// - Bit 4 of 02h enables instant recovery with default gain and clamp.
// - Clearing recovery bit restores default gain and clamp.
// - Over-range input yields full-scale code; normal samples resume immediately.
// - Clamp acts every oversampling period.
// - Gain factor sets digital full-scale and hard limit.
// - Clamp level sets where soft analog limiting begins.
// - Custom gain takes effect only with bit 7 of 0Ah set.
// - Multiplier makes oversampling and serializer clocks from input clock.
// - Bit 1 of 03h selects high loop bandwidth; default narrow.
// - Filter_equalizer_control bit disables the equalizer.
// - Filter runs from the sampling clock, scaling with it.
// - Bit and word clocks are frequency locked to input clock.
// - 0Ch bit 0 selects low swing; else bit 1 picks common mode.
// - Drive current defaults 2.5 mA, selectable 3.5 or 5 mA.
// - Termination bit enables internal 100 ohm termination.
// - Output words are 12 bits, bit tick at half the input clock rate.
module aocfg_top
  import aocfg_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter int W = `AOCFG_WORD_BITS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Serial control port
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_miso,
  // Sample path, one word per channel per oversampling tick
  input wire logic [CHANNELS*W-1:0] samples_in,
  output logic [CHANNELS*W-1:0] samples_out,
  output logic [CHANNELS-1:0] over_range,
  // Serial output framing
  output logic bit_tick,
  output logic word_tick,
  output logic os_tick,
  // Configuration state
  output logic recovery_on,
  output logic [7:0] gain_level,
  output logic [7:0] clamp_level,
  output logic high_loop_bw,
  output logic equalizer_on,
  output aocfg_outmode_t out_mode,
  output aocfg_drive_t drive_current,
  output logic tx_term_on
);
  // ==========================================================
  // Reset release
  logic [1:0] rst_sync_q;
  logic rst_core_n;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_core_n = rst_sync_q[1];

  // ==========================================================
  // Serial control slave (sampled, mode 0, 16-bit frame)
  // Frame: R/W bit, 7-bit address, 8-bit data, MSB first
  aocfg_spi_t st_q, st_d;
  logic sclk_q, sclk_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] addr_q, addr_d;
  logic rd_q, rd_d;
  logic miso_q, miso_d;
  logic wr_stb;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic rise, fall;

  assign rise = spi_sclk & ~sclk_q;
  assign fall = ~spi_sclk & sclk_q;

  // Shift on rising edges, update read data on falling edges
  always_comb begin
    st_d = st_q;
    sclk_d = spi_sclk;
    cnt_d = cnt_q;
    sh_d = sh_q;
    addr_d = addr_q;
    rd_d = rd_q;
    miso_d = miso_q;
    wr_stb = 1'b0;
    wr_data = {sh_q[6:0], spi_mosi};
    if (spi_cs_n) begin
      st_d = AOCFG_SPI_ADDR;
      cnt_d = 4'h0;
      miso_d = 1'b0;
    end else begin
      case (st_q)
        AOCFG_SPI_ADDR: begin
          if (rise) begin
            sh_d = {sh_q[6:0], spi_mosi};
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == 4'h7) begin
              rd_d = sh_q[6];
              addr_d = {1'b0, sh_q[5:0], spi_mosi};
              st_d = AOCFG_SPI_DATA;
              cnt_d = 4'h0;
            end
          end
        end
        AOCFG_SPI_DATA: begin
          if (fall) begin
            miso_d = rd_data[3'(7 - cnt_q[2:0])];
          end
          if (rise) begin
            sh_d = {sh_q[6:0], spi_mosi};
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == 4'h7) begin
              wr_stb = ~rd_q;
              st_d = AOCFG_SPI_IDLE;
            end
          end
        end
        default: begin
          st_d = AOCFG_SPI_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      st_q <= AOCFG_SPI_IDLE;
      sclk_q <= 1'b0;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      addr_q <= 8'h00;
      rd_q <= 1'b0;
      miso_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sclk_q <= sclk_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
      miso_q <= miso_d;
    end
  end
  assign spi_miso = miso_q;

  // ==========================================================
  // Register file
  logic [7:0] ovl_q, ovl_d;
  logic [7:0] lbw_q, lbw_d;
  logic [7:0] clip_q, clip_d;
  logic [7:0] eq_q, eq_d;
  logic [7:0] drv_q, drv_d;
  // Custom level fields, applied only with recovery on and custom select
  logic [7:0] cgain_q, cgain_d;
  logic [7:0] cclamp_q, cclamp_d;

  always_comb begin
    ovl_d = ovl_q;
    lbw_d = lbw_q;
    clip_d = clip_q;
    eq_d = eq_q;
    drv_d = drv_q;
    cgain_d = cgain_q;
    cclamp_d = cclamp_q;
    if (wr_stb) begin
      case (addr_q)
        `AOCFG_OFS_OVERLOAD: begin
          ovl_d = wr_data;
          if (!wr_data[`AOCFG_BIT_RECOVERY]) begin
            cgain_d = `AOCFG_DEF_GAIN;
            cclamp_d = `AOCFG_DEF_CLAMP;
          end
        end
        `AOCFG_OFS_LOOPBW: lbw_d = wr_data;
        `AOCFG_OFS_CLIPGAIN: clip_d = wr_data;
        `AOCFG_OFS_EQUALIZER: eq_d = wr_data;
        `AOCFG_OFS_OUTDRV: drv_d = wr_data;
        `AOCFG_OFS_GAIN: cgain_d = wr_data;
        `AOCFG_OFS_CLAMP: cclamp_d = wr_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      ovl_q <= `AOCFG_RST_CTRL;
      lbw_q <= `AOCFG_RST_CTRL;
      clip_q <= `AOCFG_RST_CTRL;
      eq_q <= `AOCFG_RST_CTRL;
      drv_q <= `AOCFG_RST_CTRL;
      cgain_q <= `AOCFG_DEF_GAIN;
      cclamp_q <= `AOCFG_DEF_CLAMP;
    end else begin
      ovl_q <= ovl_d;
      lbw_q <= lbw_d;
      clip_q <= clip_d;
      eq_q <= eq_d;
      drv_q <= drv_d;
      cgain_q <= cgain_d;
      cclamp_q <= cclamp_d;
    end
  end

  // ==========================================================
  // Gain and clamp selection
  // recovery bit enables mode
  assign recovery_on = ovl_q[`AOCFG_BIT_RECOVERY];
  // off, or no custom select, means defaults
  // custom gain gated by select bit
  always_comb begin
    gain_level = `AOCFG_DEF_GAIN;
    clamp_level = `AOCFG_DEF_CLAMP;
    if (recovery_on && clip_q[`AOCFG_BIT_CUSTOM_GAIN]) begin
      gain_level = cgain_q;
      clamp_level = cclamp_q;
    end
  end

  always_comb begin
    case (addr_q)
      `AOCFG_OFS_OVERLOAD: rd_data = ovl_q;
      `AOCFG_OFS_LOOPBW: rd_data = lbw_q;
      `AOCFG_OFS_CLIPGAIN: rd_data = clip_q;
      `AOCFG_OFS_EQUALIZER: rd_data = eq_q;
      `AOCFG_OFS_OUTDRV: rd_data = drv_q;
      `AOCFG_OFS_GAIN: rd_data = cgain_q;
      `AOCFG_OFS_CLAMP: rd_data = cclamp_q;
      default: rd_data = 8'h00;
    endcase
  end

  // ==========================================================
  // Clock-derived enables
  // oversampling tick from input clock
  // bit and word ticks locked to same counter
  logic [4:0] os_q, os_d;
  logic [3:0] bit_q, bit_d;
  always_comb begin
    os_d = (os_q == 5'(`AOCFG_OSR - 1)) ? 5'h00 : os_q + 5'h01;
    bit_d = bit_q;
    if (os_q[0]) begin
      bit_d = (bit_q == 4'(`AOCFG_WORD_BITS - 1)) ? 4'h0 : bit_q + 4'h1;
    end
  end
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      os_q <= 5'h00;
      bit_q <= 4'h0;
    end else begin
      os_q <= os_d;
      bit_q <= bit_d;
    end
  end
  assign os_tick = 1'b1;
  assign bit_tick = os_q[0];
  assign word_tick = os_q[0] && (bit_q == 4'h0);

  // ==========================================================
  // Output and filter controls
  // loop bandwidth select
  assign high_loop_bw = lbw_q[`AOCFG_BIT_LOOPBW];
  assign equalizer_on = ~eq_q[`AOCFG_BIT_EQ_DISABLE];
  // low swing overrides common mode select
  always_comb begin
    if (drv_q[`AOCFG_BIT_LOW_SWING]) begin
      out_mode = AOCFG_MODE_LOW_SWING;
    end else if (drv_q[`AOCFG_BIT_CM_SELECT]) begin
      out_mode = AOCFG_MODE_STANDARD;
    end else begin
      out_mode = AOCFG_MODE_REDUCED_CM;
    end
  end
  // drive current, code 3 treated as 5 mA
  always_comb begin
    case (drv_q[`AOCFG_DRIVE_LSB +: 2])
      2'b00: drive_current = AOCFG_DRIVE_2P5;
      2'b01: drive_current = AOCFG_DRIVE_3P5;
      default: drive_current = AOCFG_DRIVE_5P0;
    endcase
  end
  assign tx_term_on = drv_q[`AOCFG_BIT_TERM];

  // ==========================================================
  // Per-channel limiting
  // sampling enable drives filter
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      aocfg_clamp #(.W(W)) u_clamp (
        .clk(core_clk),
        .rst_n(rst_core_n),
        .os_tick(os_tick),
        .recovery_on(recovery_on),
        .clamp_lim(clamp_level),
        .gain_lim(gain_level),
        .sample_in(samples_in[g*W +: W]),
        .sample_out(samples_out[g*W +: W]),
        .over_range(over_range[g])
      );
    end
  endgenerate

  // ==========================================================
  // Checks
  // defaults when off
  a_default_off: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    !recovery_on |-> (gain_level == `AOCFG_DEF_GAIN && clamp_level == `AOCFG_DEF_CLAMP))
    else $error("defaults not restored");
  a_custom_gate: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    !clip_q[`AOCFG_BIT_CUSTOM_GAIN] |-> gain_level == `AOCFG_DEF_GAIN)
    else $error("custom gain without select");
  a_restore_dflt: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    wr_stb && addr_q == `AOCFG_OFS_OVERLOAD && !wr_data[`AOCFG_BIT_RECOVERY]
    |=> cgain_q == `AOCFG_DEF_GAIN && cclamp_q == `AOCFG_DEF_CLAMP)
    else $error("levels not restored");
  a_gain_field: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    wr_stb && addr_q == `AOCFG_OFS_GAIN |=> cgain_q == $past(wr_data))
    else $error("gain field not written");
  a_write_live: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    wr_stb && addr_q == `AOCFG_OFS_OVERLOAD |=> ovl_q == $past(wr_data))
    else $error("write not applied");
  a_mode_swing: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    drv_q[0] |-> out_mode == AOCFG_MODE_LOW_SWING)
    else $error("low swing not selected");
  a_word_period: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    word_tick |=> !word_tick [*8])
    else $error("word tick too frequent");
  a_clamp_order: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    clamp_level > gain_level)
    else $error("clamp not above gain");
  a_term_map: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    wr_stb && addr_q == `AOCFG_OFS_OUTDRV |=> tx_term_on == $past(wr_data[4]))
    else $error("termination not applied");
  a_bw_map: assert property (@(posedge core_clk) disable iff (!rst_core_n)
    wr_stb && addr_q == `AOCFG_OFS_LOOPBW |=> high_loop_bw == $past(wr_data[1]))
    else $error("bandwidth not applied");
  c_recovery: cover property (@(posedge core_clk) disable iff (!rst_core_n) recovery_on);
  c_over: cover property (@(posedge core_clk) disable iff (!rst_core_n) |over_range);
  c_custom: cover property (@(posedge core_clk) disable iff (!rst_core_n)
    gain_level == `AOCFG_CUSTOM_GAIN);
endmodule

// file: test/aocfg_host_model.sv
`timescale 1ns/1ps
// ==========================================
// Host controller on the serial control port
module aocfg_host_model (
  // Clock
  input wire logic core_clk,
  // Serial control port
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_mosi,
  input wire logic spi_miso
);
  // Serial clock stands low between frames
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
  end

  // One frame, command byte then data byte, MSB first
  // Four core clocks per phase leave room for the sclk synchronizer
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd,
      output logic [7:0] rdata);
    logic [15:0] sh;
    sh = {rd, a, wd};
    rdata = 8'h00;
    @(negedge core_clk);
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = sh[i];
      repeat (4) @(negedge core_clk);
      if (i < 8) begin
        rdata[i] = spi_miso;
      end
      spi_sclk = 1'b1;
      repeat (4) @(negedge core_clk);
      spi_sclk = 1'b0;
    end
    repeat (4) @(negedge core_clk);
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi; // Released line shows no stale bit
    repeat (4) @(negedge core_clk);
  endtask
endmodule

// file: test/tb_top.sv
`timescale 1ns/1ps
`include "aocfg_defs.svh"
module tb_top
  import aocfg_pkg::*;
;
  logic core_clk, rst_n, cs_n, sclk, mosi, miso;
  logic [95:0] samples_in, samples_out;
  logic [7:0] over_range, gain_level, clamp_level;
  logic bit_tick, word_tick, os_tick, recovery_on, high_loop_bw, equalizer_on, tx_term_on;
  aocfg_outmode_t out_mode;
  aocfg_drive_t drive_current;
  int miscompares = 0;
  int n_tests = 0;
  logic [7:0] ofs [5] = '{8'h02, 8'h03, 8'h0a, 8'h0b, 8'h0c};

  // ==========================================
  // Clock, device and host
  always #12.5 core_clk = ~core_clk;

  aocfg_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .spi_cs_n(cs_n), .spi_sclk(sclk),
    .spi_mosi(mosi), .spi_miso(miso), .samples_in(samples_in), .samples_out(samples_out),
    .over_range(over_range), .bit_tick(bit_tick), .word_tick(word_tick), .os_tick(os_tick),
    .recovery_on(recovery_on), .gain_level(gain_level), .clamp_level(clamp_level),
    .high_loop_bw(high_loop_bw), .equalizer_on(equalizer_on), .out_mode(out_mode),
    .drive_current(drive_current), .tx_term_on(tx_term_on));

  aocfg_host_model host_u (.core_clk(core_clk), .spi_cs_n(cs_n), .spi_sclk(sclk),
    .spi_mosi(mosi), .spi_miso(miso));

  // ==========================================
  // Shared helpers
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    host_u.xfer(1'b0, a[6:0], d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    host_u.xfer(1'b1, a[6:0], 8'h00, d);
  endtask

  // Expected mode, drive and termination decode of the output register
  function automatic logic [4:0] outdrv_exp(input logic [7:0] v);
    aocfg_outmode_t m;
    aocfg_drive_t d;
    m = v[0] ? AOCFG_MODE_LOW_SWING : (v[1] ? AOCFG_MODE_STANDARD : AOCFG_MODE_REDUCED_CM);
    d = (v[3:2] == 2'b00) ? AOCFG_DRIVE_2P5 : ((v[3:2] == 2'b01) ? AOCFG_DRIVE_3P5 :
      AOCFG_DRIVE_5P0);
    return {m, d, v[4]};
  endfunction

  // Expected limiter result {over, sample} with the clamp kept above the gain
  function automatic logic [12:0] lim_exp(input logic [11:0] s, input logic [7:0] g);
    int sv, gv;
    sv = int'($signed(s));
    gv = int'(g) * 16;
    if (sv > gv) return {1'b1, 12'h7ff};
    if (sv < -gv) return {1'b1, 12'h800};
    return {1'b0, s};
  endfunction

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog, far beyond the roughly 4000 clocks the sequence needs
  initial begin
    #(25 * 20000);
    miscompares++;
    end_of_test();
  end

  // ==========================================
  // Main sequence
  initial begin
    logic [7:0] r, v;
    int bt, wt;
    core_clk = 1'b0;
    rst_n = 1'b0;
    samples_in = '0;
    void'($urandom(32'ha9474205));
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    // Reset state of decodes and registers
    check({recovery_on, gain_level, clamp_level}, {1'b0, `AOCFG_DEF_GAIN, `AOCFG_DEF_CLAMP});
    check({high_loop_bw, equalizer_on}, 2'b01);
    check({out_mode, drive_current, tx_term_on}, outdrv_exp(8'h00));
    for (int i = 0; i < 5; i++) begin
      rd(ofs[i], r);
      check(r, `AOCFG_RST_CTRL);
    end
    // Recovery on with defaults, then custom gain
    wr(`AOCFG_OFS_OVERLOAD, 8'h10);
    check({recovery_on, gain_level, clamp_level}, {1'b1, `AOCFG_DEF_GAIN, `AOCFG_DEF_CLAMP});
    // custom clamp a0 sits above custom gain 60
    wr(`AOCFG_OFS_GAIN, `AOCFG_CUSTOM_GAIN);
    wr(`AOCFG_OFS_CLAMP, `AOCFG_CUSTOM_CLAMP);
    check({gain_level, clamp_level}, {`AOCFG_DEF_GAIN, `AOCFG_DEF_CLAMP});
    wr(`AOCFG_OFS_CLIPGAIN, 8'h80);
    check({gain_level, clamp_level}, {`AOCFG_CUSTOM_GAIN, `AOCFG_CUSTOM_CLAMP});
    rd(`AOCFG_OFS_GAIN, r);
    check(r, `AOCFG_CUSTOM_GAIN);
    rd(`AOCFG_OFS_CLAMP, r);
    check(r, `AOCFG_CUSTOM_CLAMP);
    // Overload then immediate return in range
    samples_in = {8{12'h7ff}};
    repeat (3) @(negedge core_clk);
    check(over_range, 8'hff);
    samples_in = {8{12'h100}};
    repeat (3) @(negedge core_clk);
    check(samples_out, {8{12'h100}});
    check(over_range, 8'h00);
    // Hard limit at the custom gain: boundary corners first, then random samples
    for (int k = 0; k < 16; k++) begin
      samples_in = {2{12'h600, 12'h601, 12'ha00, 12'h9ff}};
      if (k > 0) begin
        for (int c = 0; c < 8; c++) begin
          samples_in[c*12 +: 12] = 12'($urandom);
        end
      end
      repeat (2) @(negedge core_clk);
      for (int c = 0; c < 8; c++) begin
        check({over_range[c], samples_out[c*12 +: 12]},
          lim_exp(samples_in[c*12 +: 12], `AOCFG_CUSTOM_GAIN));
      end
    end
    // Clearing recovery restores defaults although custom bit stays set
    wr(`AOCFG_OFS_OVERLOAD, 8'h00);
    check({recovery_on, gain_level, clamp_level}, {1'b0, `AOCFG_DEF_GAIN, `AOCFG_DEF_CLAMP});
    rd(`AOCFG_OFS_GAIN, r);
    check(r, `AOCFG_DEF_GAIN);
    rd(`AOCFG_OFS_CLAMP, r);
    check(r, `AOCFG_DEF_CLAMP);
    // Recovery off passes a full-scale input unchanged
    samples_in = {8{12'h800}};
    repeat (2) @(negedge core_clk);
    check({over_range, samples_out}, {8'h00, {8{12'h800}}});
    wr(`AOCFG_OFS_LOOPBW, 8'h02);
    check(high_loop_bw, 1'b1);
    wr(`AOCFG_OFS_LOOPBW, 8'h00);
    check(high_loop_bw, 1'b0);
    wr(`AOCFG_OFS_EQUALIZER, 8'h01);
    check(equalizer_on, 1'b0);
    rd(`AOCFG_OFS_EQUALIZER, r);
    check(r, 8'h01);
    // Unmapped place: write ignored, reads zero
    wr(8'h05, 8'hff);
    rd(8'h05, r);
    check(r, 8'h00);
    check({recovery_on, high_loop_bw, equalizer_on}, 3'b000);
    // Output register: random bits, every drive code, common mode select alternating
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      v[1] = i[0];
      v[3:2] = i[2:1];
      wr(`AOCFG_OFS_OUTDRV, v);
      check({out_mode, drive_current, tx_term_on}, outdrv_exp(v));
    end
    // Framing ticks over two words
    bt = 0;
    wt = 0;
    for (int i = 0; i < 48; i++) begin
      @(negedge core_clk);
      bt += int'(bit_tick);
      wt += int'(word_tick);
    end
    check(bt, 24);
    check(wt, 2);
    check(os_tick, 1'b1);
    end_of_test();
  end
endmodule
